// >>> rtl/buck_ctrl_pkg.sv
// Shared constants, states and carriers for the step-down switching controller
package buck_ctrl_pkg;
	localparam int CLK_MHZ        = 200;
	// Oscillator period and non-overlap time in ns
	localparam int OSC_PERIOD_NS  = 2000;
	localparam int OSC_CYCLES     = (OSC_PERIOD_NS * CLK_MHZ) / 1000;
	localparam int DEADTIME_NS    = 20;
	localparam int DEAD_CYCLES    = (DEADTIME_NS * CLK_MHZ + 999) / 1000;
	localparam int OSC_W          = 10;
	localparam int DEAD_W         = 4;
	localparam int CNT_W          = 16;
	localparam int OVERLOAD_LIMIT = 512;
	localparam int OC_HICCUP      = 16384;
	localparam int THERM_HICCUP   = 32768;
	localparam int RAMP_W         = 10;
	localparam logic [RAMP_W-1:0] RAMP_STEP = 10'h001;

	typedef enum logic [1:0] {
		RUN     = 2'h0,
		OC_WAIT = 2'h1,
		HOT     = 2'h3,
		COOL    = 2'h2
	} mode_t;

	typedef enum logic [1:0] {
		OFF_BOTH = 2'h0,
		HIGH_ON  = 2'h1,
		LOW_ON   = 2'h3
	} phase_t;

	// Comparator results, all synchronous to clk
	typedef struct packed {
		logic peak_reached;
		logic src_over;
		logic sink_over;
		logic overvoltage;
		logic boot_low;
		logic below_light;
		logic overload;
		logic over_temp;
		logic cooled;
		logic ss_above_fb;
	} sense_t;

	// Switch commands to the drivers
	typedef struct packed {
		logic high_on;
		logic low_on;
	} gate_t;
endpackage

// >>> rtl/buck_switch_protection_control.sv
// Per-cycle switch decision, protection and hiccup timing for a step-down converter
//
// Overview of operation
// - Pre-bias start: both off until soft-start above feedback
// - Target is lower of soft-start and reference
// - Bootstrap charges below input and below regulation
// - Bootstrap undervoltage: high off, low on
// - Overvoltage keeps high-side switch off
// - After overvoltage, high resumes next cycle only
// - Peak current reached ends high-side on-time
// - Sourcing over-limit at cycle end skips next
// - Resume high only if sourcing clear at start
// - Sinking over-limit: both off until next cycle
// - Overload over 512 cycles: stop 16384 cycles
// - Over-temperature stops; cooled, wait 32768 then restart
// - Ramp added to sensed current before comparison
// - Oscillator starts high; high off turns low on
// - Below light-load peak, skip switching until above
`timescale 1ns/1ps
module buck_switch_protection_control (
	input  wire logic                                    clk,
	input  wire logic                                    rstn,
	input  wire buck_ctrl_pkg::sense_t                   sense,
	input  wire logic                                    soft_start_below_ref,
	input  wire logic                                    boot_below_vin,
	input  wire logic                                    boot_below_reg,
	output buck_ctrl_pkg::gate_t                         gate,
	output logic                                         boot_charge_en,
	output logic                                         target_is_soft_start,
	output logic [buck_ctrl_pkg::RAMP_W-1:0]             slope_ramp,
	output logic                                         switching_active,
	output logic                                         restart_soft_start
);
	typedef struct packed {
		buck_ctrl_pkg::mode_t        mode;
		buck_ctrl_pkg::phase_t       phase;
		logic [buck_ctrl_pkg::OSC_W-1:0]  osc;
		logic [buck_ctrl_pkg::CNT_W-1:0]  cnt;
		logic [buck_ctrl_pkg::CNT_W-1:0]  ol_cycles;
		logic                        light_skip;
		logic                        prebias_done;
		logic                        boot_chg;
		logic                        tgt_ss;
		logic [buck_ctrl_pkg::RAMP_W-1:0] ramp;
		logic                        restart;
		logic                        active;
	} state_t;

	state_t              s;
	state_t              next_s;
	logic                cycle_start;
	buck_ctrl_pkg::gate_t want;

	assign cycle_start = (s.osc == buck_ctrl_pkg::OSC_W'(buck_ctrl_pkg::OSC_CYCLES - 1));

	always_comb begin
		next_s = s;
		next_s.restart = 1'b0;
		next_s.boot_chg = boot_below_vin && boot_below_reg;
		next_s.tgt_ss = soft_start_below_ref;
		next_s.osc = cycle_start ? '0 : s.osc + 1'b1;
		// Ramp restarts every cycle and is summed with switch current upstream of the comparator
		next_s.ramp = cycle_start ? '0 : s.ramp + buck_ctrl_pkg::RAMP_STEP;
		if (sense.ss_above_fb) begin
			next_s.prebias_done = 1'b1;
		end
		unique case (s.mode)
			buck_ctrl_pkg::RUN: begin
				if (sense.over_temp) begin
					next_s.mode  = buck_ctrl_pkg::HOT;
					next_s.phase = buck_ctrl_pkg::OFF_BOTH;
				end else if (cycle_start) begin
					// Overload counted per cycle; more than the limit trips hiccup
					if (sense.overload) begin
						next_s.ol_cycles = s.ol_cycles + 1'b1;
					end else begin
						next_s.ol_cycles = '0;
					end
					if (sense.overload && s.ol_cycles == buck_ctrl_pkg::CNT_W'(buck_ctrl_pkg::OVERLOAD_LIMIT)) begin
						next_s.mode      = buck_ctrl_pkg::OC_WAIT;
						next_s.cnt       = '0;
						next_s.phase     = buck_ctrl_pkg::OFF_BOTH;
					end else begin
						next_s.light_skip = s.light_skip ? sense.below_light : 1'b0;
						if (!s.prebias_done && !sense.ss_above_fb) begin
							next_s.phase = buck_ctrl_pkg::OFF_BOTH;
						end else if (sense.src_over) begin
							next_s.phase = buck_ctrl_pkg::LOW_ON;
						end else if (sense.overvoltage || s.light_skip) begin
							// Turn-on is decided only here, so a cleared overvoltage waits for a cycle start
							next_s.phase = buck_ctrl_pkg::OFF_BOTH;
						end else begin
							next_s.phase = buck_ctrl_pkg::HIGH_ON;
						end
					end
				end else begin
					unique case (s.phase)
						buck_ctrl_pkg::HIGH_ON: begin
							if (sense.overvoltage || sense.boot_low || sense.peak_reached) begin
								next_s.phase = buck_ctrl_pkg::LOW_ON;
							end
							if (sense.peak_reached && sense.below_light) begin
								next_s.light_skip = 1'b1;
							end
						end
						buck_ctrl_pkg::LOW_ON: begin
							if (sense.sink_over) begin
								next_s.phase = buck_ctrl_pkg::OFF_BOTH;
							end
						end
						buck_ctrl_pkg::OFF_BOTH: begin
							if (sense.boot_low && s.prebias_done) begin
								next_s.phase = buck_ctrl_pkg::LOW_ON;
							end
						end
						default: next_s.phase = buck_ctrl_pkg::OFF_BOTH;
					endcase
				end
			end
			buck_ctrl_pkg::OC_WAIT: begin
				next_s.phase = buck_ctrl_pkg::OFF_BOTH;
				if (cycle_start) begin
					next_s.cnt = s.cnt + 1'b1;
					if (s.cnt == buck_ctrl_pkg::CNT_W'(buck_ctrl_pkg::OC_HICCUP - 1)) begin
						next_s.mode = buck_ctrl_pkg::RUN;
						next_s.ol_cycles = '0;
						next_s.prebias_done = 1'b0;
						next_s.restart = 1'b1;
					end
				end
			end
			buck_ctrl_pkg::HOT: begin
				next_s.phase = buck_ctrl_pkg::OFF_BOTH;
				next_s.cnt = '0;
				if (sense.cooled && !sense.over_temp) begin
					next_s.mode = buck_ctrl_pkg::COOL;
				end
			end
			buck_ctrl_pkg::COOL: begin
				next_s.phase = buck_ctrl_pkg::OFF_BOTH;
				if (sense.over_temp) begin
					next_s.mode = buck_ctrl_pkg::HOT;
				end else if (cycle_start) begin
					next_s.cnt = s.cnt + 1'b1;
					if (s.cnt == buck_ctrl_pkg::CNT_W'(buck_ctrl_pkg::THERM_HICCUP - 1)) begin
						next_s.mode = buck_ctrl_pkg::RUN;
						next_s.ol_cycles = '0;
						next_s.prebias_done = 1'b0;
						next_s.restart = 1'b1;
					end
				end
			end
			default: next_s.mode = buck_ctrl_pkg::RUN;
		endcase
		// Sink limit overrides any late decision, except at a cycle start
		if (s.phase == buck_ctrl_pkg::LOW_ON && sense.sink_over && !cycle_start) begin
			next_s.phase = buck_ctrl_pkg::OFF_BOTH;
		end
		next_s.active = (next_s.mode == buck_ctrl_pkg::RUN);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			// Mode resets to run, so the activity flag reads high in reset
			s.active <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	always_comb begin
		want.high_on = (s.phase == buck_ctrl_pkg::HIGH_ON);
		want.low_on  = (s.phase == buck_ctrl_pkg::LOW_ON);
	end

	// Adds the non-overlap gap; gate outputs come from its flip-flops
	gate_nonoverlap u_gate (
		.clk   (clk),
		.rstn  (rstn),
		.want  (want),
		.drive (gate)
	);

	assign boot_charge_en       = s.boot_chg;
	assign target_is_soft_start = s.tgt_ss;
	assign slope_ramp           = s.ramp;
	assign switching_active     = s.active;
	assign restart_soft_start   = s.restart;

	sequence hiccup_entry;
		s.mode == buck_ctrl_pkg::RUN ##1 s.mode == buck_ctrl_pkg::OC_WAIT;
	endsequence

	AST_OV_NO_HIGH: assert property (@(posedge clk) disable iff (!rstn)
		sense.overvoltage |=> s.phase != buck_ctrl_pkg::HIGH_ON)
		else $error("high on during overvoltage");
	AST_PEAK_OFF: assert property (@(posedge clk) disable iff (!rstn)
		(s.phase == buck_ctrl_pkg::HIGH_ON && sense.peak_reached && !cycle_start && s.mode == buck_ctrl_pkg::RUN && !sense.over_temp)
		|=> s.phase == buck_ctrl_pkg::LOW_ON)
		else $error("high not ended at peak");
	AST_SRC_SKIP: assert property (@(posedge clk) disable iff (!rstn)
		(cycle_start && sense.src_over && s.mode == buck_ctrl_pkg::RUN && s.prebias_done && !sense.over_temp
		&& !sense.overload) |=> s.phase == buck_ctrl_pkg::LOW_ON)
		else $error("sourcing limit did not skip");
	AST_SINK_OFF: assert property (@(posedge clk) disable iff (!rstn)
		(s.phase == buck_ctrl_pkg::LOW_ON && sense.sink_over && !cycle_start) |=> s.phase == buck_ctrl_pkg::OFF_BOTH)
		else $error("low not off at sink limit");
	AST_HIGH_ONLY_AT_START: assert property (@(posedge clk) disable iff (!rstn)
		$rose(s.phase == buck_ctrl_pkg::HIGH_ON) |-> $past(cycle_start) && !$past(sense.src_over)
		&& !$past(sense.overvoltage))
		else $error("high turned on mid cycle");
	AST_HICCUP_QUIET: assert property (@(posedge clk) disable iff (!rstn)
		hiccup_entry |-> s.phase == buck_ctrl_pkg::OFF_BOTH [*8])
		else $error("switching during hiccup");
	AST_HOT_STOP: assert property (@(posedge clk) disable iff (!rstn)
		sense.over_temp |=> s.phase == buck_ctrl_pkg::OFF_BOTH)
		else $error("switching while hot");
	AST_PREBIAS: assert property (@(posedge clk) disable iff (!rstn)
		!s.prebias_done |-> s.phase == buck_ctrl_pkg::OFF_BOTH)
		else $error("switch on before soft-start above feedback");
	AST_BOOT: assert property (@(posedge clk) disable iff (!rstn)
		(boot_below_vin && boot_below_reg) |=> boot_charge_en)
		else $error("bootstrap charge not enabled");
	AST_BOOT_OFF: assert property (@(posedge clk) disable iff (!rstn)
		!(boot_below_vin && boot_below_reg) |=> !boot_charge_en)
		else $error("bootstrap charge enabled outside its window");
	AST_BOOT_LOW: assert property (@(posedge clk) disable iff (!rstn)
		(s.phase == buck_ctrl_pkg::HIGH_ON && sense.boot_low && !cycle_start && s.mode == buck_ctrl_pkg::RUN
		&& !sense.over_temp) |=> s.phase == buck_ctrl_pkg::LOW_ON)
		else $error("bootstrap low did not hand over to low side");
	AST_LIGHT_SKIP: assert property (@(posedge clk) disable iff (!rstn)
		(cycle_start && s.light_skip && s.mode == buck_ctrl_pkg::RUN) |=> s.phase != buck_ctrl_pkg::HIGH_ON)
		else $error("high on during light-load skip");
endmodule

// >>> rtl/gate_nonoverlap.sv
// Break-before-make stage between switch requests and gate drivers
`timescale 1ns/1ps
module gate_nonoverlap (
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire buck_ctrl_pkg::gate_t want,
	output buck_ctrl_pkg::gate_t      drive
);
	typedef struct packed {
		buck_ctrl_pkg::gate_t          g;
		logic [buck_ctrl_pkg::DEAD_W-1:0] dead;
	} nstate_t;

	nstate_t s;
	nstate_t next_s;

	always_comb begin
		next_s = s;
		if (s.dead != '0) begin
			next_s.dead = s.dead - 1'b1;
		end
		// Any turn-off is immediate; a turn-on waits out the dead time
		if (!want.high_on) begin
			next_s.g.high_on = 1'b0;
		end
		if (!want.low_on) begin
			next_s.g.low_on = 1'b0;
		end
		if ((s.g.high_on && !want.high_on) || (s.g.low_on && !want.low_on)) begin
			next_s.dead = buck_ctrl_pkg::DEAD_W'(buck_ctrl_pkg::DEAD_CYCLES);
		end else if (s.dead == '0 && !s.g.high_on && !s.g.low_on) begin
			// Never both on, high side wins ties
			if (want.high_on) begin
				next_s.g.high_on = 1'b1;
			end else if (want.low_on) begin
				next_s.g.low_on = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign drive = s.g;

	AST_NO_SHOOT: assert property (@(posedge clk) disable iff (!rstn) !(s.g.high_on && s.g.low_on))
		else $error("both switches on");
	AST_DEAD_GAP: assert property (@(posedge clk) disable iff (!rstn)
		$fell(s.g.low_on) |-> !s.g.high_on [*4])
		else $error("no gap after low-side off");
endmodule

// >>> sim/power_stage_model.sv
// Behavioural power stage: peak-current comparator and gate overlap monitor
`timescale 1ns/1ps
module power_stage_model #(
	parameter int ON_CLKS = 40
) (
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire buck_ctrl_pkg::gate_t gate,
	output logic                      peak_reached,
	output logic                      overlap_seen
);
	int on_cnt;

	// Switch current ramps while the high side conducts, so the trip comes after a fixed on-time
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			on_cnt       <= 0;
			overlap_seen <= 1'b0;
		end else begin
			on_cnt <= gate.high_on ? on_cnt + 1 : 0;
			if (gate.high_on && gate.low_on)
				overlap_seen <= 1'b1;
		end
	end

	assign peak_reached = gate.high_on && (on_cnt >= ON_CLKS);
endmodule

// >>> sim/testbench.sv
// Self-checking bench for the switching and protection controller
`timescale 1ns/1ps
module testbench;
	localparam int ON_CLKS = 40;
	logic                      clk          = 1'b0;
	logic                      rstn         = 1'b0;
	buck_ctrl_pkg::sense_t     faults       = '0;
	buck_ctrl_pkg::sense_t     sense;
	logic                      ss_below     = 1'b0;
	logic                      bvin         = 1'b0;
	logic                      breg         = 1'b0;
	buck_ctrl_pkg::gate_t      gate;
	logic                      boot_charge_en;
	logic                      target_is_soft_start;
	logic [9:0]                slope_ramp;
	logic                      switching_active;
	logic                      restart;
	logic                      peak;
	logic                      overlap_seen;
	int                        num_errors   = 0;
	int                        total_checks = 0;
	int                        hi;
	int                        lo;

	always #2.5 clk = ~clk;

	always_comb begin
		sense              = faults;
		sense.peak_reached = peak;
	end

	buck_switch_protection_control buck_switch_protection_control_i (
		.clk(clk), .rstn(rstn), .sense(sense), .soft_start_below_ref(ss_below),
		.boot_below_vin(bvin), .boot_below_reg(breg), .gate(gate), .boot_charge_en(boot_charge_en),
		.target_is_soft_start(target_is_soft_start), .slope_ramp(slope_ramp),
		.switching_active(switching_active), .restart_soft_start(restart)
	);

	power_stage_model #(.ON_CLKS(ON_CLKS)) power_stage_model_i (
		.clk(clk), .rstn(rstn), .gate(gate), .peak_reached(peak), .overlap_seen(overlap_seen)
	);

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Inputs always move 1 ns after the edge, away from sampling
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic watch(input int n);
		hi = 0;
		lo = 0;
		repeat (n) begin
			tick(1);
			hi += (gate.high_on === 1'b1);
			lo += (gate.low_on === 1'b1);
		end
	endtask

	// Ramp mirrors the oscillator count, so it places stimulus inside a switching cycle
	task automatic wait_ramp(input logic [9:0] v);
		int k;
		for (k = 0; k < 1000 && slope_ramp !== v; k++)
			tick(1);
		if (k == 1000) begin
			num_errors++;
			test_done();
		end
	endtask

	task automatic t_prebias;
		ss_below = 1'b1;
		bvin     = 1'b1;
		breg     = 1'b1;
		watch(900);
		check("prebias high", 16'(hi), 16'h0000);
		check("prebias low", 16'(lo), 16'h0000);
		check("target", target_is_soft_start, 1'b1);
		check("boot charge", boot_charge_en, 1'b1);
		ss_below = 1'b0;
		breg     = 1'b0;
		tick(3);
		check("target", target_is_soft_start, 1'b0);
		check("boot charge", boot_charge_en, 1'b0);
		$display("test prebias done");
	endtask

	task automatic t_normal;
		faults.ss_above_fb = 1'b1;
		watch(1200);
		check("high on", hi != 0, 1'b1);
		check("low on", lo != 0, 1'b1);
		check("on time", hi <= 4 * (ON_CLKS + 4), 1'b1);
		wait_ramp(10'h005);
		tick(1);
		check("ramp", slope_ramp, 10'h006);
		$display("test normal done");
	endtask

	task automatic t_overvolt;
		faults.overvoltage = 1'b1;
		watch(400);
		watch(900);
		check("ov high", 16'(hi), 16'h0000);
		wait_ramp(10'h064);
		faults.overvoltage = 1'b0;
		watch(250);
		check("ov mid cycle", 16'(hi), 16'h0000);
		watch(200);
		check("ov resume", hi != 0, 1'b1);
		$display("test overvoltage done");
	endtask

	task automatic t_source;
		faults.src_over = 1'b1;
		watch(400);
		watch(900);
		check("src high", 16'(hi), 16'h0000);
		check("src low held", lo >= 850, 1'b1);
		faults.src_over = 1'b0;
		watch(1200);
		check("src resume", hi != 0, 1'b1);
		$display("test source limit done");
	endtask

	task automatic t_sink;
		// Early in the cycle, so the off window is not cut short by the next cycle start
		wait_ramp(10'h03C);
		check("sink low before", gate.low_on, 1'b1);
		faults.sink_over = 1'b1;
		tick(3);
		check("sink low off", gate.low_on, 1'b0);
		faults.sink_over = 1'b0;
		watch(150);
		check("sink high", 16'(hi), 16'h0000);
		check("sink low", 16'(lo), 16'h0000);
		watch(300);
		check("sink resume", hi != 0, 1'b1);
		$display("test sink limit done");
	endtask

	task automatic t_light;
		faults.below_light = 1'b1;
		watch(900);
		watch(800);
		check("light high", 16'(hi), 16'h0000);
		faults.below_light = 1'b0;
		watch(1200);
		check("light resume", hi != 0, 1'b1);
		$display("test light load done");
	endtask

	task automatic t_boot;
		faults.boot_low = 1'b1;
		watch(400);
		watch(800);
		check("boot high", 16'(hi), 16'h0000);
		check("boot low on", lo >= 750, 1'b1);
		faults.boot_low = 1'b0;
		watch(900);
		check("boot resume", hi != 0, 1'b1);
		$display("test bootstrap done");
	endtask

	task automatic t_hot;
		faults.over_temp = 1'b1;
		tick(3);
		check("hot active", switching_active, 1'b0);
		watch(900);
		check("hot high", 16'(hi), 16'h0000);
		check("hot low", 16'(lo), 16'h0000);
		check("overlap", overlap_seen, 1'b0);
		// Cooled: the restart count is far longer than this window, so all stays off
		faults.over_temp = 1'b0;
		faults.cooled    = 1'b1;
		watch(2000);
		check("cool high", 16'(hi), 16'h0000);
		check("cool low", 16'(lo), 16'h0000);
		check("cool active", switching_active, 1'b0);
		check("restart", restart, 1'b0);
		$display("test thermal done");
	endtask

	initial begin
		tick(3);
		rstn = 1'b1;
		t_prebias();
		t_normal();
		t_overvolt();
		t_source();
		t_sink();
		t_light();
		t_boot();
		t_hot();
		test_done();
	end
endmodule
